// ### design/cbf_defines.svh
/*
 Constants of the transfer, bit and flag execution unit: status flag
 bit positions, reset values and address widths.
 Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef CBF_DEFINES_SVH
`define CBF_DEFINES_SVH

// Status flag bit positions
`define CBF_FLAG_C 0
`define CBF_FLAG_Z 1
`define CBF_FLAG_N 2
`define CBF_FLAG_V 3
`define CBF_FLAG_S 4
`define CBF_FLAG_H 5
`define CBF_FLAG_T 6
`define CBF_FLAG_I 7

// Reset values
`define CBF_FLAGS_RESET 8'h00
`define CBF_SP_RESET    16'h0fff

// Widths and register count
`define CBF_IO_AW   6
`define CBF_MEM_AW  16
`define CBF_NREGS   32

// Z pointer register pair
`define CBF_ZL_IDX 5'h1e
`define CBF_ZH_IDX 5'h1f

`endif

// ### design/cbf_pkg.sv
/*
 Types of the transfer, bit and flag execution unit: operation codes,
 controller states and the packed state record.
 Assumes cbf_defines.svh is reachable by bare name.
*/
package cbf_pkg;
`include "cbf_defines.svh"

   // Operations that the unit executes
   typedef enum logic [4:0] {
      OP_NOP              = 5'h00,
      OP_IO_READ          = 5'h01,
      OP_IO_WRITE         = 5'h02,
      OP_PUSH             = 5'h03,
      OP_POP              = 5'h04,
      OP_LOAD_AND_SET     = 5'h05,
      OP_LOAD_AND_CLEAR   = 5'h06,
      OP_LOAD_AND_TOGGLE  = 5'h07,
      OP_ROTATE_LEFT      = 5'h08,
      OP_ROTATE_RIGHT     = 5'h09,
      OP_SET_IO_BIT       = 5'h0a,
      OP_CLEAR_IO_BIT     = 5'h0b,
      OP_STORE_BIT_T      = 5'h0c,
      OP_LOAD_BIT_T       = 5'h0d,
      OP_SET_SIGN         = 5'h0e,
      OP_CLEAR_SIGN       = 5'h0f,
      OP_SET_OVERFLOW     = 5'h10,
      OP_CLEAR_OVERFLOW   = 5'h11,
      OP_SET_HALF_CARRY   = 5'h12,
      OP_CLEAR_HALF_CARRY = 5'h13
   } cbf_op_t;

   // Controller states, one-hot
   typedef enum logic [2:0] {
      ST_RUN  = 3'b001,
      ST_DATA = 3'b010,
      ST_PAD  = 3'b100
   } cbf_fsm_t;

   // Whole state of the unit
   typedef struct packed {
      cbf_fsm_t                          st;
      logic                              ready;
      logic [`CBF_NREGS-1:0][7:0]        regs;
      logic [7:0]                        flags;
      logic [`CBF_MEM_AW-1:0]            sp;
      cbf_op_t                           op;
      logic [4:0]                        rd;
      logic [7:0]                        tmp;
      logic                              internal;
      logic                              in_pend;
      logic [4:0]                        in_rd;
      logic [`CBF_MEM_AW-1:0]            mem_addr;
      logic [7:0]                        mem_wdata;
      logic                              mem_re;
      logic                              mem_we;
      logic [`CBF_IO_AW-1:0]             io_addr;
      logic [7:0]                        io_wdata;
      logic                              io_re;
      logic                              io_we;
      logic                              io_set;
      logic                              io_clr;
      logic [2:0]                        io_bit;
      logic [7:0]                        reg_val;
   } cbf_state_t;

endpackage

// ### design/cbf_rot_unit.sv
/*
 Rotate-through-carry datapath with its flag results.
 Assumes a purely combinational use inside the execution unit.
*/
`timescale 1ns/1ns
`include "cbf_defines.svh"

module cbf_rot_unit
   import cbf_pkg::*;
(
   input  wire logic [7:0] operand,
   input  wire logic [7:0] flags_in,
   input  wire logic       to_right,
   output logic      [7:0] result,
   output logic      [7:0] flags_out
);
   logic carry_out;

   // Shift one place, old carry fills the vacated end
   always_comb begin
      flags_out = flags_in;
      if (to_right) begin
         result    = {flags_in[`CBF_FLAG_C], operand[7:1]};
         carry_out = operand[0];
      end else begin
         result    = {operand[6:0], flags_in[`CBF_FLAG_C]};
         carry_out = operand[7];
         flags_out[`CBF_FLAG_H] = operand[3];
      end
      // S and T are left alone, only Z C N V (and H for left) move
      flags_out[`CBF_FLAG_C] = carry_out;
      flags_out[`CBF_FLAG_Z] = (result == 8'h00);
      flags_out[`CBF_FLAG_N] = result[7];
      flags_out[`CBF_FLAG_V] = result[7] ^ carry_out;
   end
endmodule

// ### design/cbf_exec_unit.sv
/*
 Execution unit for I/O and stack transfers, atomic memory updates via
 the Z pointer, rotates, I/O bit set/clear, T-flag bit moves and the
 S, V and H flag set/clear operations. Holds the register file, status
 flags and stack pointer.
 Assumes memory and I/O answer on the same clock: io_rdata is valid
 while io_re is high, mem_rdata while mem_re is high and mem_wait is low.
*/
`timescale 1ns/1ns
`include "cbf_defines.svh"

module cbf_exec_unit
   import cbf_pkg::*;
(
   input  wire logic                   sys_clk,
   input  wire logic                   reset_n,
   input  wire logic                   cmd_valid,
   input  wire cbf_op_t                cmd_op,
   input  wire logic [4:0]             cmd_reg,
   input  wire logic [2:0]             cmd_bit,
   input  wire logic [`CBF_IO_AW-1:0]  cmd_io_addr,
   input  wire logic                   cmd_mem_internal,
   output logic                        cmd_ready,
   input  wire logic [7:0]             io_rdata,
   output logic [`CBF_IO_AW-1:0]       io_addr,
   output logic [7:0]                  io_wdata,
   output logic                        io_re,
   output logic                        io_we,
   output logic                        io_set,
   output logic                        io_clr,
   output logic [2:0]                  io_bit,
   input  wire logic [7:0]             mem_rdata,
   input  wire logic                   mem_wait,
   output logic [`CBF_MEM_AW-1:0]      mem_addr,
   output logic [7:0]                  mem_wdata,
   output logic                        mem_re,
   output logic                        mem_we,
   output logic [7:0]                  flags,
   output logic [`CBF_MEM_AW-1:0]      sp,
   input  wire logic [4:0]             reg_sel,
   output logic [7:0]                  reg_val
);
   localparam cbf_state_t STATE_RESET = '{
      st:    ST_RUN,
      ready: 1'b1,
      flags: `CBF_FLAGS_RESET,
      sp:    `CBF_SP_RESET,
      op:    OP_NOP,
      default: '0
   };

   cbf_state_t s_q;
   cbf_state_t s_d;
   logic       accept;
   logic [7:0] opnd;
   logic [7:0] rot_res;
   logic [7:0] rot_flags;

   // Register read with bypass of a still pending I/O read result
   function automatic logic [7:0] reg_read(cbf_state_t s, logic [4:0] idx,
                                           logic [7:0] iod);
      if (s.in_pend && s.in_rd == idx)
         return iod;
      return s.regs[idx];
   endfunction

   // Memory image written back by the atomic updates
   function automatic logic [7:0] rmw_value(cbf_op_t op, logic [7:0] r,
                                            logic [7:0] m);
      unique case (op)
         OP_LOAD_AND_SET:   return r | m;
         OP_LOAD_AND_CLEAR: return ~r & m;
         default:           return r ^ m;
      endcase
   endfunction

   assign accept = cmd_valid && s_q.ready;
   assign opnd   = reg_read(s_q, cmd_reg, io_rdata);

   cbf_rot_unit u_rot (
      .operand   (opnd),
      .flags_in  (s_q.flags),
      .to_right  (cmd_op == OP_ROTATE_RIGHT),
      .result    (rot_res),
      .flags_out (rot_flags)
   );

   // Next state of the whole unit
   always_comb begin
      s_d = s_q;
      s_d.io_re   = 1'b0;
      s_d.io_we   = 1'b0;
      s_d.io_set  = 1'b0;
      s_d.io_clr  = 1'b0;
      s_d.mem_re  = 1'b0;
      s_d.mem_we  = 1'b0;
      s_d.in_pend = 1'b0;
      // Finish an I/O read issued last cycle
      if (s_q.in_pend)
         s_d.regs[s_q.in_rd] = io_rdata;
      unique case (s_q.st)
         ST_RUN: begin
            if (accept) begin
               s_d.op       = cmd_op;
               s_d.rd       = cmd_reg;
               s_d.tmp      = opnd;
               s_d.internal = cmd_mem_internal;
               unique case (cmd_op)
                  OP_NOP: begin
                  end
                  OP_IO_READ: begin
                     s_d.io_addr = cmd_io_addr;
                     s_d.io_re   = 1'b1;
                     s_d.in_pend = 1'b1;
                     s_d.in_rd   = cmd_reg;
                  end
                  OP_IO_WRITE: begin
                     s_d.io_addr  = cmd_io_addr;
                     s_d.io_wdata = opnd;
                     s_d.io_we    = 1'b1;
                  end
                  OP_PUSH: begin
                     // Writes are posted, mem_wait does not hold them
                     s_d.mem_addr  = s_q.sp;
                     s_d.mem_wdata = opnd;
                     s_d.mem_we    = 1'b1;
                     s_d.sp        = s_q.sp - 16'h0001;
                     if (cmd_mem_internal)
                        s_d.st = ST_PAD;
                  end
                  OP_POP: begin
                     s_d.sp       = s_q.sp + 16'h0001;
                     s_d.mem_addr = s_q.sp + 16'h0001;
                     s_d.mem_re   = 1'b1;
                     s_d.st       = ST_DATA;
                  end
                  OP_LOAD_AND_SET, OP_LOAD_AND_CLEAR,
                  OP_LOAD_AND_TOGGLE: begin
                     // Z pointer is the top register pair
                     s_d.mem_addr = {reg_read(s_q, `CBF_ZH_IDX, io_rdata),
                                     reg_read(s_q, `CBF_ZL_IDX, io_rdata)};
                     s_d.mem_re   = 1'b1;
                     s_d.st       = ST_DATA;
                  end
                  OP_ROTATE_LEFT, OP_ROTATE_RIGHT: begin
                     s_d.regs[cmd_reg] = rot_res;
                     s_d.flags         = rot_flags;
                  end
                  OP_SET_IO_BIT: begin
                     s_d.io_addr = cmd_io_addr;
                     s_d.io_bit  = cmd_bit;
                     s_d.io_set  = 1'b1;
                  end
                  OP_CLEAR_IO_BIT: begin
                     s_d.io_addr = cmd_io_addr;
                     s_d.io_bit  = cmd_bit;
                     s_d.io_clr  = 1'b1;
                  end
                  OP_STORE_BIT_T:
                     s_d.flags[`CBF_FLAG_T] = opnd[cmd_bit];
                  OP_LOAD_BIT_T:
                     s_d.regs[cmd_reg][cmd_bit] =
                        s_q.flags[`CBF_FLAG_T];
                  OP_SET_SIGN:
                     s_d.flags[`CBF_FLAG_S] = 1'b1;
                  OP_CLEAR_SIGN:
                     s_d.flags[`CBF_FLAG_S] = 1'b0;
                  OP_SET_OVERFLOW:
                     s_d.flags[`CBF_FLAG_V] = 1'b1;
                  OP_CLEAR_OVERFLOW:
                     s_d.flags[`CBF_FLAG_V] = 1'b0;
                  OP_SET_HALF_CARRY:
                     s_d.flags[`CBF_FLAG_H] = 1'b1;
                  OP_CLEAR_HALF_CARRY:
                     s_d.flags[`CBF_FLAG_H] = 1'b0;
               endcase
            end
         end
         ST_DATA: begin
            // External memory may stretch the read as long as it likes
            if (mem_wait) begin
               s_d.mem_re = 1'b1;
            end else begin
               s_d.regs[s_q.rd] = mem_rdata;
               if (s_q.op != OP_POP) begin
                  s_d.mem_we    = 1'b1;
                  s_d.mem_wdata = rmw_value(s_q.op, s_q.tmp, mem_rdata);
               end
               s_d.st = s_q.internal ? ST_PAD : ST_RUN;
            end
         end
         ST_PAD:
            s_d.st = ST_RUN;
         default:
            s_d.st = ST_RUN;
      endcase
      s_d.ready   = (s_d.st == ST_RUN);
      s_d.reg_val = s_d.regs[reg_sel];
   end

   // Single state register
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n)
         s_q <= STATE_RESET;
      else
         s_q <= s_d;
   end

   assign cmd_ready = s_q.ready;
   assign io_addr   = s_q.io_addr;
   assign io_wdata  = s_q.io_wdata;
   assign io_re     = s_q.io_re;
   assign io_we     = s_q.io_we;
   assign io_set    = s_q.io_set;
   assign io_clr    = s_q.io_clr;
   assign io_bit    = s_q.io_bit;
   assign mem_addr  = s_q.mem_addr;
   assign mem_wdata = s_q.mem_wdata;
   assign mem_re    = s_q.mem_re;
   assign mem_we    = s_q.mem_we;
   assign flags     = s_q.flags;
   assign sp        = s_q.sp;
   assign reg_val   = s_q.reg_val;

   // Checks on timing and flag effects
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);

   io_read_a: assert property (
      accept && cmd_op == OP_IO_READ |=> io_re && cmd_ready
         && io_addr == $past(cmd_io_addr) && flags == $past(flags))
      else $error("I/O read not one clock or flags moved");

   push_time_a: assert property (
      accept && cmd_op == OP_PUSH && cmd_mem_internal
         |=> mem_we && !cmd_ready && sp == $past(sp) - 16'h0001
         ##1 cmd_ready)
      else $error("push timing wrong");

   pop_time_a: assert property (
      accept && cmd_op == OP_POP && cmd_mem_internal ##1 !mem_wait
         |-> !cmd_ready ##1 !cmd_ready ##1 cmd_ready)
      else $error("pop timing wrong");

   set_write_a: assert property (
      accept && cmd_op == OP_LOAD_AND_SET ##1 !mem_wait
         |=> mem_we && mem_wdata == ($past(mem_rdata) | s_q.tmp))
      else $error("load-and-set write value wrong");

   clear_write_a: assert property (
      accept && cmd_op == OP_LOAD_AND_CLEAR ##1 !mem_wait
         |=> mem_we && mem_wdata == ($past(mem_rdata) & ~s_q.tmp))
      else $error("load-and-clear write value wrong");

   toggle_write_a: assert property (
      accept && cmd_op == OP_LOAD_AND_TOGGLE ##1 !mem_wait
         |=> mem_we && mem_wdata == ($past(mem_rdata) ^ s_q.tmp)
         && flags == $past(flags, 2))
      else $error("load-and-toggle wrong");

   rotl_flags_a: assert property (
      accept && cmd_op == OP_ROTATE_LEFT |=>
         flags[`CBF_FLAG_C] == $past(opnd[7])
         && flags[`CBF_FLAG_S] == $past(flags[`CBF_FLAG_S]))
      else $error("rotate left flags wrong");

   rotr_keep_h_a: assert property (
      accept && cmd_op == OP_ROTATE_RIGHT |=>
         flags[`CBF_FLAG_H] == $past(flags[`CBF_FLAG_H])
         && flags[`CBF_FLAG_C] == $past(opnd[0]))
      else $error("rotate right flags wrong");

   io_bit_a: assert property (
      accept && (cmd_op == OP_SET_IO_BIT || cmd_op == OP_CLEAR_IO_BIT)
         |=> (io_set != io_clr) && !io_we && io_bit == $past(cmd_bit))
      else $error("I/O bit strobe wrong");

   t_store_a: assert property (
      accept && cmd_op == OP_STORE_BIT_T |=>
         flags == (($past(flags) & ~8'h40)
                  | ({7'h00, $past(opnd[cmd_bit])} << `CBF_FLAG_T)))
      else $error("bit store to T wrong");

   sign_flag_a: assert property (
      accept && cmd_op == OP_SET_SIGN |=> flags == ($past(flags) | 8'h10))
      else $error("sign flag set wrong");

   ovf_flag_a: assert property (
      accept && cmd_op == OP_CLEAR_OVERFLOW
         |=> flags == ($past(flags) & ~8'h08))
      else $error("overflow flag clear wrong");
endmodule

// ### tb/cbf_mem_model.sv
/*
 Behavioural data memory and I/O register space facing the execution
 unit. Assumes one clock, posted writes and one-cycle strobes.
*/
`timescale 1ns/1ns
`include "cbf_defines.svh"

module cbf_mem_model (
   input  wire logic                   sys_clk,
   input  wire logic [`CBF_IO_AW-1:0]  io_addr,
   input  wire logic [7:0]             io_wdata,
   input  wire logic                   io_re,
   input  wire logic                   io_we,
   input  wire logic                   io_set,
   input  wire logic                   io_clr,
   input  wire logic [2:0]             io_bit,
   input  wire logic [`CBF_MEM_AW-1:0] mem_addr,
   input  wire logic [7:0]             mem_wdata,
   input  wire logic                   mem_re,
   input  wire logic                   mem_we,
   input  wire logic [3:0]             stall,
   output logic      [7:0]             io_rdata,
   output logic      [7:0]             mem_rdata,
   output logic                        mem_wait
);
   logic [7:0] mem [4096];
   logic [7:0] io  [64];
   logic [3:0] wcnt = 4'h0;

   // Wait states of a slow external memory, counted per read
   assign mem_wait = mem_re && (wcnt < stall);
   always @(posedge sys_clk)
      wcnt <= mem_wait ? wcnt + 4'h1 : 4'h0;

   // Inverse data outside valid cycles, so a late sample is caught
   assign mem_rdata = (mem_re && !mem_wait) ? mem[mem_addr[11:0]]
                                            : ~mem[mem_addr[11:0]];
   assign io_rdata  = io_re ? io[io_addr] : ~io[io_addr];

   // Posted writes and single-bit updates from the strobes
   always @(posedge sys_clk) begin
      if (mem_we)
         mem[mem_addr[11:0]] <= mem_wdata;
      if (io_we)
         io[io_addr] <= io_wdata;
      if (io_set)
         io[io_addr][io_bit] <= 1'b1;
      if (io_clr)
         io[io_addr][io_bit] <= 1'b0;
   end
endmodule

// ### tb/cbf_exec_unit_test.sv
/*
 Self-checking bench of the execution unit with its memory model.
 Assumes cbf_pkg is compiled first and the model file is present.
*/
`timescale 1ns/1ns
`include "cbf_defines.svh"

module cbf_exec_unit_test
   import cbf_pkg::*;
;
   logic                   sys_clk = 1'b0;
   logic                   reset_n = 1'b0;
   logic                   cmd_valid = 1'b0;
   cbf_op_t                cmd_op = OP_NOP;
   logic [4:0]             cmd_reg = 5'h00;
   logic [2:0]             cmd_bit = 3'h0;
   logic [`CBF_IO_AW-1:0]  cmd_io_addr = 6'h00;
   logic                   cmd_mem_internal = 1'b0;
   logic [4:0]             reg_sel = 5'h00;
   logic [3:0]             stall = 4'h0;
   logic                   cmd_ready, io_re, io_we, io_set, io_clr;
   logic                   mem_re, mem_we, mem_wait;
   logic [7:0]             io_rdata, io_wdata, mem_rdata, mem_wdata;
   logic [7:0]             flags, reg_val;
   logic [2:0]             io_bit;
   logic [`CBF_IO_AW-1:0]  io_addr;
   logic [`CBF_MEM_AW-1:0] mem_addr, sp;
   int                     n_mismatch = 0;
   int                     samples_checked = 0;

   cbf_exec_unit dut (.sys_clk(sys_clk), .reset_n(reset_n),
      .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_reg(cmd_reg),
      .cmd_bit(cmd_bit), .cmd_io_addr(cmd_io_addr),
      .cmd_mem_internal(cmd_mem_internal), .cmd_ready(cmd_ready),
      .io_rdata(io_rdata), .io_addr(io_addr), .io_wdata(io_wdata),
      .io_re(io_re), .io_we(io_we), .io_set(io_set), .io_clr(io_clr),
      .io_bit(io_bit), .mem_rdata(mem_rdata), .mem_wait(mem_wait),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_re(mem_re),
      .mem_we(mem_we), .flags(flags), .sp(sp), .reg_sel(reg_sel),
      .reg_val(reg_val));

   cbf_mem_model mm (.sys_clk(sys_clk), .io_addr(io_addr),
      .io_wdata(io_wdata), .io_re(io_re), .io_we(io_we),
      .io_set(io_set), .io_clr(io_clr), .io_bit(io_bit),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_re(mem_re),
      .mem_we(mem_we), .stall(stall), .io_rdata(io_rdata),
      .mem_rdata(mem_rdata), .mem_wait(mem_wait));

   // 100 MHz clock
   always #5 sys_clk = ~sys_clk;

   task automatic print_verdict;
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: seen %h expected %h",
                  $time, seen, exp);
      end
   endtask

   // Edges until ready is sampled high; a hang ends the run
   task automatic wait_ready(output int n);
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (cmd_ready !== 1'b1 && n < 50);
      if (cmd_ready !== 1'b1) begin
         n_mismatch++;
         print_verdict;
      end
   endtask

   // One command; n is the clocks from acceptance to ready again
   task automatic exec(input cbf_op_t op, input logic [4:0] r,
         input logic [2:0] b, input logic [5:0] a, input logic mi,
         output int n);
      int k;
      @(posedge sys_clk);
      cmd_valid <= 1'b1;
      cmd_op <= op;
      cmd_reg <= r;
      cmd_bit <= b;
      cmd_io_addr <= a;
      cmd_mem_internal <= mi;
      wait_ready(k);
      cmd_valid <= 1'b0;
      wait_ready(n);
   endtask

   // Register read back, one cycle late through reg_sel
   task automatic rd(input logic [4:0] r, output logic [7:0] v);
      @(posedge sys_clk);
      reg_sel <= r;
      @(posedge sys_clk);
      #1 v = reg_val;
   endtask

   // Registers have no direct load port; this task loads one through the I/O path
   task automatic ld(input logic [4:0] r, input logic [7:0] v);
      int n;
      // Mid-cycle, so a read landing on this edge keeps its old value
      @(negedge sys_clk);
      mm.io[6'h3f] = v;
      exec(OP_IO_READ, r, 3'h0, 6'h3f, 1'b0, n);
   endtask

   task automatic t_io;
      int n;
      logic [7:0] v;
      mm.io[6'h05] = 8'ha5;
      exec(OP_IO_READ, 5'h03, 3'h0, 6'h05, 1'b0, n);
      chk(16'(n), 16'h1);
      rd(5'h03, v);
      chk(v, 8'ha5);
      exec(OP_IO_WRITE, 5'h03, 3'h0, 6'h09, 1'b0, n);
      chk(16'(n), 16'h1);
      #1 chk(mm.io[6'h09], 8'ha5);
      chk(flags, 8'h00);
      $display("test io done");
   endtask

   task automatic t_stack;
      int n;
      logic [7:0] v;
      exec(OP_PUSH, 5'h03, 3'h0, 6'h00, 1'b0, n);
      chk(16'(n), 16'h1);
      #1 chk(sp, 16'h0ffe);
      chk(mm.mem[12'hfff], 8'ha5);
      exec(OP_POP, 5'h04, 3'h0, 6'h00, 1'b1, n);
      chk(16'(n), 16'h3);
      rd(5'h04, v);
      chk(v, 8'ha5);
      chk(sp, 16'h0fff);
      exec(OP_PUSH, 5'h03, 3'h0, 6'h00, 1'b1, n);
      chk(16'(n), 16'h2);
      stall <= 4'h2;
      exec(OP_POP, 5'h07, 3'h0, 6'h00, 1'b0, n);
      stall <= 4'h0;
      chk(16'(n), 16'h4);
      rd(5'h07, v);
      chk(v, 8'ha5);
      chk(flags, 8'h00);
      $display("test stack done");
   endtask

   task automatic t_atomic;
      cbf_op_t    ops [3] = '{OP_LOAD_AND_SET, OP_LOAD_AND_CLEAR,
                              OP_LOAD_AND_TOGGLE};
      logic [7:0] exp [3] = '{8'hbd, 8'h81, 8'h99};
      int n;
      logic [7:0] v;
      ld(`CBF_ZL_IDX, 8'h00);
      ld(`CBF_ZH_IDX, 8'h01);
      for (int i = 0; i < 3; i++) begin
         mm.mem[12'h100] = 8'ha5;
         ld(5'h05, 8'h3c);
         exec(ops[i], 5'h05, 3'h0, 6'h00, 1'b1, n);
         chk(16'(n), 16'h3);
         rd(5'h05, v);
         chk(v, 8'ha5);
         chk(mm.mem[12'h100], exp[i]);
      end
      chk(flags, 8'h00);
      $display("test atomic done");
   endtask

   task automatic t_rotate;
      cbf_op_t    ops [4] = '{OP_ROTATE_LEFT, OP_ROTATE_LEFT,
                              OP_SET_HALF_CARRY, OP_ROTATE_RIGHT};
      logic [7:0] fx  [4] = '{8'h0b, 8'h00, 8'h20, 8'h2b};
      logic [7:0] rx  [4] = '{8'h00, 8'h01, 8'h01, 8'h00};
      int n;
      logic [7:0] v;
      ld(5'h06, 8'h80);
      for (int i = 0; i < 4; i++) begin
         exec(ops[i], 5'h06, 3'h0, 6'h00, 1'b0, n);
         chk(16'(n), 16'h1);
         #1 chk(flags, fx[i]);
         rd(5'h06, v);
         chk(v, rx[i]);
      end
      $display("test rotate done");
   endtask

   task automatic t_iobits;
      int n;
      logic [7:0] f;
      f = flags;
      mm.io[6'h0a] = 8'h00;
      exec(OP_SET_IO_BIT, 5'h00, 3'h7, 6'h0a, 1'b0, n);
      chk(16'(n), 16'h1);
      #1 chk(mm.io[6'h0a], 8'h80);
      mm.io[6'h0a] = 8'hff;
      exec(OP_CLEAR_IO_BIT, 5'h00, 3'h2, 6'h0a, 1'b0, n);
      chk(16'(n), 16'h1);
      #1 chk(mm.io[6'h0a], 8'hfb);
      chk(flags, f);
      $display("test io bits done");
   endtask

   task automatic t_tbit;
      int n;
      logic [7:0] f, v;
      f = flags;
      ld(5'h08, 8'ha5);
      ld(5'h09, 8'h00);
      exec(OP_STORE_BIT_T, 5'h08, 3'h5, 6'h00, 1'b0, n);
      #1 chk(flags, f | 8'h40);
      exec(OP_LOAD_BIT_T, 5'h09, 3'h4, 6'h00, 1'b0, n);
      chk(16'(n), 16'h1);
      rd(5'h09, v);
      chk(v, 8'h10);
      chk(flags, f | 8'h40);
      exec(OP_STORE_BIT_T, 5'h09, 3'h0, 6'h00, 1'b0, n);
      #1 chk(flags, f & 8'hbf);
      $display("test t bit done");
   endtask

   task automatic t_flags;
      cbf_op_t ops [6] = '{OP_CLEAR_OVERFLOW, OP_SET_OVERFLOW,
         OP_CLEAR_HALF_CARRY, OP_SET_HALF_CARRY, OP_SET_SIGN,
         OP_CLEAR_SIGN};
      int      pos [6] = '{3, 3, 5, 5, 4, 4};
      int n;
      logic [7:0] e;
      for (int i = 0; i < 6; i++) begin
         e = flags;
         e[pos[i]] = (i == 1 || i == 3 || i == 4);
         exec(ops[i], 5'h00, 3'h0, 6'h00, 1'b0, n);
         chk(16'(n), 16'h1);
         #1 chk(flags, e);
      end
      // An idle command must cost one clock and touch nothing
      exec(OP_NOP, 5'h00, 3'h0, 6'h00, 1'b0, n);
      chk(16'(n), 16'h1);
      #1 chk(flags, e);
      $display("test flags done");
   endtask

   // Reset for ten cycles, then every scenario in turn
   initial begin
      repeat (10) @(posedge sys_clk);
      reset_n <= 1'b1;
      #1 chk(flags, `CBF_FLAGS_RESET);
      chk(sp, `CBF_SP_RESET);
      chk(cmd_ready, 1'b1);
      t_io;
      t_stack;
      t_atomic;
      t_rotate;
      t_iobits;
      t_tbit;
      t_flags;
      print_verdict;
   end
endmodule
